// ---- pkg/iftc_map.vh ----
`ifndef IFTC_MAP_VH
`define IFTC_MAP_VH
// register word addresses (avalon word index)
`define IFTC_A_NTC 3'h0
`define IFTC_A_VEC 3'h1
`define IFTC_A_RF0 3'h2
`define IFTC_A_RF1 3'h3
`define IFTC_A_RF2 3'h4
`define IFTC_A_IPL 3'h5
// field positions
`define IFTC_NSTD_BIT 15
`define IFTC_ARITH_BIT 4
`define IFTC_ADDR_BIT 3
`define IFTC_STACK_BIT 2
`define IFTC_OSC_BIT 1
`define IFTC_ALT_BIT 15
`define IFTC_TDIS_BIT 14
// implemented-bit masks
`define IFTC_NTC_MASK 16'h801e
`define IFTC_RF0_MASK 16'h3fef
`define IFTC_RF1_MASK 16'hfe1f
`define IFTC_RF2_MASK 16'h2280
// external input positions within request flags
`define IFTC_EXT0_BIT 0
`define IFTC_EXT1_BIT 4
`define IFTC_EXT2_BIT 13
`define IFTC_RST16 16'h0000
`define IFTC_RST3 3'h0
`endif

// ---- rtl/iftc_edge_det.v ----
`timescale 1ns/100ps
module iftc_edge_det (
   core_clk,
   rst,
   pin_in,
   falling_sel,
   edge_pulse
);
   input wire core_clk;
   input wire rst;
   input wire pin_in;
   input wire falling_sel;
   output wire edge_pulse;

   reg sync0_r;
   reg sync1_r;
   reg prev_r;

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sync0_r <= 1'b0;
         sync1_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         sync0_r <= pin_in;
         sync1_r <= sync0_r;
         prev_r <= sync1_r;
      end
   end

   // polarity one selects the falling edge
   assign edge_pulse = falling_sel ? (prev_r & ~sync1_r) :
                                     (~prev_r & sync1_r); // RQ9
endmodule

// ---- rtl/iftc_top.v ----
// What this block does
// RQ1: read/write nesting disable at bit 15 of control one, reset clear.
// RQ2: arithmetic trap sets bit 4 of control one; zero otherwise.
// RQ3: address error trap sets bit 3 of control one.
// RQ4: stack error trap sets bit 2 of control one.
// RQ5: oscillator failure trap sets bit 1 of control one.
// RQ6: unimplemented bits of both control registers read zero.
// RQ7: bit 15 of control two selects alternate vector table.
// RQ8: read-only bit 14 of control two shows temporary disable active.
// RQ9: polarity bits 2..0 pick falling edge when one, rising when zero.
// RQ10: implemented flag bits are read/write and reset to zero.
// RQ11: flags 0 bits 13..8 latch converter, uart1, spi1, timer3 requests.
// RQ12: flags 0 bits 7..5 and 3..0 latch timers, compares, captures, ext0.
// RQ13: flags 1 bits 15..9 latch uart2, ext2, timers, compares.
// RQ14: flags 1 bits 4..0 latch ext1, change, comparator, i2c1.
// RQ15: flags 2 bit 13 parallel port, bit 9 compare 5, bit 7 capture 5; others zero.
// RQ16: flags 2 bit 7 latches capture 5 until cleared.
// RQ17: sources set flags; only software writes clear them.
// RQ18: priority level bits become read-only while nesting disabled.
// RQ19: software writing one to a flag sets it like hardware.
// RQ20: trap bits stay set until written zero; new trap wins.
//
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
`include "iftc_map.vh"
module iftc_top (
   core_clk,
   rst,
   avs_address,
   avs_read,
   avs_write,
   avs_writedata,
   avs_byteenable,
   avs_readdata,
   avs_waitrequest,
   arith_trap,
   addr_trap,
   stack_trap,
   osc_fail_trap,
   temp_disable_active,
   ext0_pin,
   ext1_pin,
   ext2_pin,
   rf0_src,
   rf1_src,
   rf2_src,
   nesting_disable,
   alt_table_select,
   cpu_priority_level,
   request_flags_0,
   request_flags_1,
   request_flags_2
);
   input wire core_clk;
   input wire rst;
   input wire [2:0] avs_address;
   input wire avs_read;
   input wire avs_write;
   input wire [31:0] avs_writedata;
   input wire [3:0] avs_byteenable;
   output reg [31:0] avs_readdata;
   output wire avs_waitrequest;
   input wire arith_trap;
   input wire addr_trap;
   input wire stack_trap;
   input wire osc_fail_trap;
   input wire temp_disable_active;
   input wire ext0_pin;
   input wire ext1_pin;
   input wire ext2_pin;
   input wire [15:0] rf0_src;
   input wire [15:0] rf1_src;
   input wire [15:0] rf2_src;
   output wire nesting_disable;
   output wire alt_table_select;
   output wire [2:0] cpu_priority_level;
   output wire [15:0] request_flags_0;
   output wire [15:0] request_flags_1;
   output wire [15:0] request_flags_2;

   reg [15:0] ntc_r;
   reg [15:0] ntc_nxt;
   reg alt_r;
   reg [2:0] pol_r;
   reg [2:0] ipl_r;
   reg [15:0] rf0_r;
   reg [15:0] rf1_r;
   reg [15:0] rf2_r;
   reg [15:0] rf0_nxt;
   reg [15:0] rf1_nxt;
   reg [15:0] rf2_nxt;
   reg ack_r;
   reg [15:0] rd_nxt;
   wire [15:0] trap_set;
   wire [15:0] ext_set;
   wire [2:0] ext_edge;
   wire [15:0] wdata;
   wire wr_go;
   wire rd_go;

   // one wait cycle for every access, so each takes two edges
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
   assign wr_go = avs_write & ack_r;
   assign rd_go = avs_read & ~ack_r;

   // lane 0 and 1 carry the 16-bit register; masked lanes keep old bits
   function [15:0] merge;
      input [15:0] old;
      input [15:0] nw;
      input [1:0] be;
      begin
         merge = {be[1] ? nw[15:8] : old[15:8],
                  be[0] ? nw[7:0] : old[7:0]};
      end
   endfunction

   assign wdata = avs_writedata[15:0];

   iftc_edge_det u_ext0 (
      .core_clk(core_clk),
      .rst(rst),
      .pin_in(ext0_pin),
      .falling_sel(pol_r[0]),
      .edge_pulse(ext_edge[0])
   );
   iftc_edge_det u_ext1 (
      .core_clk(core_clk),
      .rst(rst),
      .pin_in(ext1_pin),
      .falling_sel(pol_r[1]),
      .edge_pulse(ext_edge[1])
   );
   iftc_edge_det u_ext2 (
      .core_clk(core_clk),
      .rst(rst),
      .pin_in(ext2_pin),
      .falling_sel(pol_r[2]),
      .edge_pulse(ext_edge[2])
   );

   assign trap_set = ({15'h0000, arith_trap} << `IFTC_ARITH_BIT) |
                     ({15'h0000, addr_trap} << `IFTC_ADDR_BIT) |
                     ({15'h0000, stack_trap} << `IFTC_STACK_BIT) |
                     ({15'h0000, osc_fail_trap} << `IFTC_OSC_BIT);
   assign ext_set = ({15'h0000, ext_edge[0]} << `IFTC_EXT0_BIT) |
                    ({15'h0000, ext_edge[1]} << `IFTC_EXT1_BIT) |
                    ({15'h0000, ext_edge[2]} << `IFTC_EXT2_BIT);

   // next values: software write first, then hardware sets win
   always @* begin
      ntc_nxt = ntc_r;
      rf0_nxt = rf0_r;
      rf1_nxt = rf1_r;
      rf2_nxt = rf2_r;
      if (wr_go) begin
         case (avs_address)
            `IFTC_A_NTC: ntc_nxt = merge(ntc_r, wdata,
                                         avs_byteenable[1:0]); // RQ1
            `IFTC_A_RF0: rf0_nxt = merge(rf0_r, wdata,
                                         avs_byteenable[1:0]); // RQ19
            `IFTC_A_RF1: rf1_nxt = merge(rf1_r, wdata,
                                         avs_byteenable[1:0]); // RQ19
            `IFTC_A_RF2: rf2_nxt = merge(rf2_r, wdata,
                                         avs_byteenable[1:0]); // RQ19
            default: ntc_nxt = ntc_r;
         endcase
      end
      ntc_nxt = (ntc_nxt | trap_set) & `IFTC_NTC_MASK; // RQ20
      rf0_nxt = (rf0_nxt | rf0_src | (ext_set & 16'h0001))
                & `IFTC_RF0_MASK; // RQ11
      rf1_nxt = (rf1_nxt | rf1_src | (ext_set & 16'h2010))
                & `IFTC_RF1_MASK; // RQ13
      rf2_nxt = (rf2_nxt | rf2_src) & `IFTC_RF2_MASK; // RQ16
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ntc_r <= `IFTC_RST16;
         rf0_r <= `IFTC_RST16; // RQ10
         rf1_r <= `IFTC_RST16;
         rf2_r <= `IFTC_RST16;
         alt_r <= 1'b0;
         pol_r <= `IFTC_RST3;
         ipl_r <= `IFTC_RST3;
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read | avs_write) & ~ack_r;
         ntc_r <= ntc_nxt; // RQ2 RQ3 RQ4 RQ5
         rf0_r <= rf0_nxt; // RQ12
         rf1_r <= rf1_nxt; // RQ14
         rf2_r <= rf2_nxt; // RQ15 RQ17
         if (wr_go && avs_address == `IFTC_A_VEC) begin
            if (avs_byteenable[1])
               alt_r <= wdata[`IFTC_ALT_BIT]; // RQ7
            if (avs_byteenable[0])
               pol_r <= wdata[2:0]; // RQ9
         end
         if (wr_go && avs_address == `IFTC_A_IPL && avs_byteenable[0] &&
             !ntc_r[`IFTC_NSTD_BIT])
            ipl_r <= wdata[2:0]; // RQ18
      end
   end

   always @* begin
      case (avs_address)
         `IFTC_A_NTC: rd_nxt = ntc_r; // RQ6
         `IFTC_A_VEC: rd_nxt = {alt_r, temp_disable_active, 11'h000,
                                pol_r}; // RQ6 RQ8
         `IFTC_A_RF0: rd_nxt = rf0_r;
         `IFTC_A_RF1: rd_nxt = rf1_r;
         `IFTC_A_RF2: rd_nxt = rf2_r;
         `IFTC_A_IPL: rd_nxt = {13'h0000, ipl_r};
         default: rd_nxt = `IFTC_RST16;
      endcase
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst)
         avs_readdata <= 32'h00000000;
      else if (rd_go)
         avs_readdata <= {16'h0000, rd_nxt};
   end

   assign nesting_disable = ntc_r[`IFTC_NSTD_BIT];
   assign alt_table_select = alt_r;
   assign cpu_priority_level = ipl_r;
   assign request_flags_0 = rf0_r;
   assign request_flags_1 = rf1_r;
   assign request_flags_2 = rf2_r;
endmodule

// ---- tb/iftc_src_model.sv ----
`timescale 1ns/100ps
module iftc_src_model (
   input logic core_clk,
   input logic [55:0] cmd,
   output logic [55:0] drv = 56'h0
);
   // peripheral, trap, pin and core lines follow commands a cycle later
   always @(posedge core_clk) begin
      drv <= cmd;
   end
endmodule

// ---- tb/iftc_top_props.sv ----
`timescale 1ns/100ps
`include "iftc_map.vh"
module iftc_top_props (
   input logic core_clk,
   input logic rst,
   input logic [2:0] avs_address,
   input logic avs_read,
   input logic avs_write,
   input logic [31:0] avs_writedata,
   input logic [3:0] avs_byteenable,
   input logic avs_waitrequest,
   input logic [15:0] rf0_src,
   input logic [15:0] rf1_src,
   input logic nesting_disable,
   input logic alt_table_select,
   input logic [2:0] cpu_priority_level,
   input logic [15:0] request_flags_0,
   input logic [15:0] request_flags_1
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence wr_acc(a);
      avs_write && !avs_waitrequest && avs_address == a;
   endsequence
   sequence rd_req;
      avs_read && avs_waitrequest;
   endsequence
   one_wait_a: assert property (rd_req |=> !avs_waitrequest)
      else $error("read held more than one wait state");
   nest_wr_a: assert property (wr_acc(3'h0) ##0 avs_byteenable[1] |=>
      nesting_disable == $past(avs_writedata[15])) else $error("nest bit");
   alt_wr_a: assert property (wr_acc(3'h1) ##0 avs_byteenable[1] |=>
      alt_table_select == $past(avs_writedata[15])) else $error("alt bit");
   ipl_lock_a: assert property (nesting_disable ##0 wr_acc(3'h5) |=>
      $stable(cpu_priority_level)) else $error("level written while locked");
   set_f0_a: assert property (1'b1 |=>
      (($past(rf0_src) & `IFTC_RF0_MASK & ~request_flags_0) == 16'h0))
      else $error("flags0 request lost");
   set_f1_a: assert property (1'b1 |=>
      (($past(rf1_src) & `IFTC_RF1_MASK & ~request_flags_1) == 16'h0))
      else $error("flags1 request lost");
   unimpl_a: assert property ((request_flags_0 & ~`IFTC_RF0_MASK) == 16'h0
      && (request_flags_1 & ~`IFTC_RF1_MASK) == 16'h0) else $error("unimpl");
   flag_hold_a: assert property (request_flags_1[4] && !(avs_write &&
      !avs_waitrequest && avs_address == 3'h3) |=> request_flags_1[4])
      else $error("flag cleared by itself");
endmodule
bind iftc_top iftc_top_props iftc_top_props_i (.*);

// ---- tb/tb_iftc_top.sv ----
`timescale 1ns/100ps
`include "iftc_map.vh"
module tb_iftc_top;
   logic core_clk = 1'h0, rst = 1'h1, avs_read = 1'h0, avs_write = 1'h0;
   logic [2:0] avs_address = 3'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h3, be = 4'h3;
   logic [55:0] cmd = 56'h0;
   logic [15:0] q;
   logic [15:0] m[3] = '{`IFTC_RF0_MASK, `IFTC_RF1_MASK, `IFTC_RF2_MASK};
   wire [55:0] drv;
   wire [31:0] avs_readdata;
   wire avs_waitrequest;
   int n_mismatch = 0, checks_done = 0, i;
   always #5 core_clk = ~core_clk;
   iftc_src_model iftc_src_model_i (.core_clk(core_clk), .cmd(cmd), .drv(drv));
   iftc_top iftc_top_i (.core_clk(core_clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .osc_fail_trap(drv[48]), .stack_trap(drv[49]), .addr_trap(drv[50]),
      .arith_trap(drv[51]), .ext0_pin(drv[52]), .ext1_pin(drv[53]),
      .ext2_pin(drv[54]), .temp_disable_active(drv[55]),
      .rf0_src(drv[15:0]), .rf1_src(drv[31:16]), .rf2_src(drv[47:32]),
      .nesting_disable(), .alt_table_select(), .cpu_priority_level(),
      .request_flags_0(), .request_flags_1(), .request_flags_2());
   task report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task bus(input logic w, input logic [2:0] a, input logic [15:0] d);
      int k;
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= {16'h0, d};
      avs_byteenable <= be;
      avs_read <= !w;
      avs_write <= w;
      k = 0;
      // waitrequest and readdata are read before this edge's updates land
      do begin
         @(posedge core_clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 20);
      q = avs_readdata[15:0];
      if (avs_waitrequest !== 1'b0) begin
         n_mismatch++;
         $display("MISMATCH %0t bus access never answered", $time);
         report_and_stop;
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task rd(input logic [2:0] a, input logic [15:0] e);
      bus(1'b0, a, 16'h0);
      checks_done++;
      if (q !== e) begin
         n_mismatch++;
         $display("MISMATCH %0t reg %0d got %h exp %h", $time, a, q, e);
      end
   endtask
   task pls(input logic [55:0] v);
      @(posedge core_clk);
      cmd <= cmd | v;
      @(posedge core_clk);
      cmd <= cmd & ~v;
   endtask
   task pin_wait(input logic [2:0] p);
      cmd[54:52] <= p;
      repeat (8) @(posedge core_clk);
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      for (i = 0; i < 8; i++) rd(i, 16'h0);
      be = 4'h1;
      bus(1'b1, 3'h0, 16'hffff);
      be = 4'h3;
      rd(3'h0, 16'h001e);
      bus(1'b1, 3'h0, 16'hffff);
      rd(3'h0, 16'h801e);
      bus(1'b1, 3'h5, 16'h0007);
      rd(3'h5, 16'h0);
      bus(1'b1, 3'h0, 16'h0);
      bus(1'b1, 3'h5, 16'h0005);
      rd(3'h5, 16'h0005);
      bus(1'b1, 3'h1, 16'hffff);
      rd(3'h1, 16'h8007);
      cmd[55] <= 1'b1;
      rd(3'h1, 16'hc007);
      cmd[55] <= 1'b0;
      for (i = 0; i < 4; i++) begin
         pls(56'h1 << (48 + i));
         rd(3'h0, 16'h0002 << i);
         bus(1'b1, 3'h0, 16'h0);
      end
      // trap held across the clearing write must survive it
      cmd[51] <= 1'b1;
      bus(1'b1, 3'h0, 16'h0);
      cmd[51] <= 1'b0;
      rd(3'h0, 16'h0010);
      bus(1'b1, 3'h0, 16'h0);
      pls({8'h0, {48{1'b1}}});
      for (i = 0; i < 3; i++) begin
         rd(i + 2, m[i]);
         bus(1'b1, i + 2, 16'h0);
         rd(i + 2, 16'h0);
         bus(1'b1, i + 2, 16'hffff);
         rd(i + 2, m[i]);
         bus(1'b1, i + 2, 16'h0);
      end
      // polarity is all ones here: rising pins must be ignored
      pin_wait(3'h7);
      rd(3'h2, 16'h0);
      rd(3'h3, 16'h0);
      pin_wait(3'h0);
      rd(3'h2, 16'h0001);
      rd(3'h3, 16'h2010);
      bus(1'b1, 3'h2, 16'h0);
      bus(1'b1, 3'h3, 16'h0);
      bus(1'b1, 3'h1, 16'h0);
      pin_wait(3'h7);
      rd(3'h2, 16'h0001);
      rd(3'h3, 16'h2010);
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      $display("MISMATCH %0t run timed out", $time);
      report_and_stop;
   end
endmodule
